// [logic/farx_pkg.sv]
// Shared constants and types for the far-end alarm code receiver.
// Assumes a 32-bit APB slave port with word-aligned register offsets.
`default_nettype none
package farx_pkg;

   // Register byte offsets
   localparam logic [11:0] ADDR_CONFIG = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_CODE   = 12'h008;
   localparam logic [11:0] ADDR_STACK  = 12'h00c;

   // Code word layout, first received bit at index 0
   localparam int CW_BITS      = 16;
   localparam int CW_ONES_HI   = 7;
   localparam int CW_ZERO_LO   = 8;
   localparam int CW_PAY_LO    = 9;
   localparam int CW_PAY_HI    = 14;
   localparam int CW_ZERO_HI   = 15;
   localparam int PAY_W        = 6;
   localparam logic [7:0] CW_ONES = 8'hff;

   // Multiple-word detection figures
   localparam int CNT_W          = 4;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_TWO = 4'h2;
   localparam logic [3:0] CNT_DONE = 4'h9;

   // Idle run and code word lengths in bits
   localparam logic [4:0] IDLE_RUN = 5'h10;
   localparam logic [4:0] BITS_FULL = 5'h10;

   // Status register fields
   localparam int ST_NEW_MSG   = 0;
   localparam int ST_TO_IDLE   = 1;
   localparam int ST_NOT_EMPTY = 2;
   localparam int ST_IN_MSG    = 3;

   // Stack read word fields
   localparam int SK_VALID = 6;
   localparam int SK_MORE  = 7;

   // Reset value of the configuration register: all interrupts masked
   localparam logic [3:0] CONFIG_RESET = 4'h0;

   typedef enum logic [1:0] {
      FMT_DS3_M13,
      FMT_DS3_CBIT,
      FMT_E3_G751,
      FMT_E3_G832
   } farx_fmt_t;

   typedef struct packed {
      logic stack_not_empty_irq_enable;
      logic return_to_idle_irq_enable;
      logic new_message_irq_enable;
      logic single_word_detect_select;
   } farx_config_t;

endpackage
`default_nettype wire

// [logic/farx_receiver.sv]
// Far-end alarm code receiver: code word hunt, idle detect, message
// state, latest code byte, payload stack and an APB register slave.
// Assumes c13_valid marks each C13 overhead bit taken from the framer,
// synchronous to pclk, and that the framer reports the line format.
//
// Notes on behaviour
// - Only C13 overhead bits of C-bit parity frames feed the receiver.
// - Pattern is 16 bits: eight ones, zero, six payload bits, zero.
// - Receiver held inactive in M13/M23 and both E3 formats.
// - Config bit chooses single-word or multiple-word detection.
// - Single mode declares a valid code word on one complete pattern.
// - Multiple mode needs nine matching patterns via tentative/alternative.
// - First pattern loads tentative word, counter one, go tentative step.
// - Tentative step: match adds one, else load alternative word.
// - Tentative-alternative step: match with tentative adds two.
// - Else alternative becomes tentative; counter two or one.
// - Counter at nine or more declares valid; comparison is exact.
// - Overhead bit errors void a pattern (this receiver has no error input, so no pattern is voided); bits between patterns ignored.
// - Sixteen consecutive ones form a valid idle condition.
// - Valid word loads byte, sets new flag, enters message; read clears.
// - Idle in message state sets return flag, back to idle state.
// - New valid word overwrites an unread code byte.
// - Receiver gated by channel_enable; separate masks for new and idle interrupts.
// - Three-deep stack; full push drops oldest; no overrun alert.
// - Stack read gives oldest payload with valid and more bits.
// - Not-empty status bit raises interrupt unless masked.
// - Push on changed payload, empty stack, or leaving idle.
`default_nettype none
module farx_receiver #(
   parameter int DEPTH = 3
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                clk_en,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   input  wire farx_pkg::farx_fmt_t line_format,
   input  wire logic                channel_enable,
   input  wire logic                c13_bit,
   input  wire logic                c13_valid,
   output var  logic                irq
);

   if (DEPTH < 2) begin : g_depth_check
      $error("farx_receiver: DEPTH must be at least 2");
   end

   localparam int PW = farx_pkg::PAY_W;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_C   = CW'(1);

   typedef enum logic [1:0] {
      ALG_INIT,
      ALG_TENT,
      ALG_TALT
   } farx_alg_t;

   typedef enum logic {
      MSG_IDLE,
      MSG_ACTIVE
   } farx_msg_t;

   function automatic logic farx_is_pattern(input logic [15:0] w);
      return (w[farx_pkg::CW_ONES_HI:0] == farx_pkg::CW_ONES)
         && !w[farx_pkg::CW_ZERO_LO] && !w[farx_pkg::CW_ZERO_HI];
   endfunction

   function automatic logic [PW-1:0] farx_payload(input logic [15:0] w);
      return w[farx_pkg::CW_PAY_HI:farx_pkg::CW_PAY_LO];
   endfunction

   farx_pkg::farx_config_t cfg;
   logic [15:0]            shift;
   logic [4:0]             nbits;
   logic [4:0]             ones_run;
   farx_alg_t              alg;
   logic [3:0]             rep;
   logic [PW-1:0]          tent;
   logic [PW-1:0]          alt;
   farx_msg_t              msg_state;
   logic [PW-1:0]          code_byte;
   logic                   new_message_flag;
   logic                   return_to_idle_flag;
   logic [PW-1:0]          last_code;
   logic                   from_idle;
   logic [PW-1:0]          stack [DEPTH];
   logic [CW-1:0]          fill;

   logic                   active;
   logic                   bit_in;
   logic [15:0]            next_shift;
   logic                   pattern_hit;
   logic [PW-1:0]          pay;
   logic                   idle_hit;
   logic                   word_valid;
   logic [3:0]             next_rep_tent;
   logic [3:0]             next_rep_two;
   logic                   push;
   logic                   pop;
   logic                   stack_not_empty;
   logic                   acc;
   logic                   rd_code;
   logic                   rd_status;

   assign active = channel_enable
      && (line_format == farx_pkg::FMT_DS3_CBIT);
   assign bit_in = active && c13_valid;
   assign next_shift = {c13_bit, shift[15:1]};
   // Fresh 16 bits are required after each hit, so trailing data is ignored
   assign pattern_hit = bit_in && (nbits >= farx_pkg::BITS_FULL - 5'h1)
      && farx_is_pattern(next_shift);
   assign pay = farx_payload(next_shift);
   assign idle_hit = bit_in && c13_bit
      && (ones_run == farx_pkg::IDLE_RUN - 5'h1);
   assign next_rep_tent = rep + farx_pkg::CNT_ONE;
   assign next_rep_two  = rep + farx_pkg::CNT_TWO;

   always_comb begin
      word_valid = 1'b0;
      if (pattern_hit) begin
         if (cfg.single_word_detect_select) begin
            word_valid = 1'b1;
         end else begin
            case (alg)
               ALG_TENT: begin
                  word_valid = (pay == tent)
                     && (next_rep_tent >= farx_pkg::CNT_DONE);
               end
               ALG_TALT: begin
                  word_valid = (pay == tent)
                     && (next_rep_two >= farx_pkg::CNT_DONE);
               end
               default: begin
                  word_valid = 1'b0;
               end
            endcase
         end
      end
   end

   assign stack_not_empty = (fill != '0);
   assign acc = psel && penable && pready;
   assign rd_code   = acc && !pwrite && (paddr == farx_pkg::ADDR_CODE);
   assign rd_status = acc && !pwrite && (paddr == farx_pkg::ADDR_STATUS);
   assign pop = acc && !pwrite && (paddr == farx_pkg::ADDR_STACK)
      && stack_not_empty;
   assign push = word_valid
      && (from_idle || !stack_not_empty || pay != last_code);

   // Bit collection and idle run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift    <= '0;
         nbits    <= '0;
         ones_run <= '0;
      end else if (clk_en) begin
         if (!active) begin
            nbits    <= '0;
            ones_run <= '0;
         end else if (bit_in) begin
            shift <= next_shift;
            if (pattern_hit) begin
               nbits <= '0;
            end else if (nbits < farx_pkg::BITS_FULL) begin
               nbits <= nbits + 5'h1;
            end
            if (!c13_bit) begin
               ones_run <= '0;
            end else if (ones_run < farx_pkg::IDLE_RUN) begin
               ones_run <= ones_run + 5'h1;
            end
         end
      end
   end

   // Multiple-word detection walk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alg  <= ALG_INIT;
         rep  <= '0;
         tent <= '0;
         alt  <= '0;
      end else if (clk_en) begin
         if (!active || cfg.single_word_detect_select) begin
            alg <= ALG_INIT;
         end else if (pattern_hit) begin
            case (alg)
               ALG_INIT: begin
                  tent <= pay;
                  rep  <= farx_pkg::CNT_ONE;
                  alg  <= ALG_TENT;
               end
               ALG_TENT: begin
                  if (pay == tent) begin
                     rep <= next_rep_tent;
                     alg <= word_valid ? ALG_INIT : ALG_TENT;
                  end else begin
                     alt <= pay;
                     alg <= ALG_TALT;
                  end
               end
               ALG_TALT: begin
                  if (pay == tent) begin
                     rep <= next_rep_two;
                     alg <= word_valid ? ALG_INIT : ALG_TENT;
                  end else begin
                     tent <= alt;
                     if (pay == alt) begin
                        rep <= farx_pkg::CNT_TWO;
                        alg <= ALG_TENT;
                     end else begin
                        rep <= farx_pkg::CNT_ONE;
                        alt <= pay;
                        alg <= ALG_TALT;
                     end
                  end
               end
               default: begin
                  alg <= ALG_INIT;
               end
            endcase
         end
      end
   end

   // Message state, code byte and flags; a set beats a read-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_state           <= MSG_IDLE;
         code_byte           <= '0;
         new_message_flag    <= 1'b0;
         return_to_idle_flag <= 1'b0;
      end else if (clk_en) begin
         case (msg_state)
            MSG_IDLE: begin
               if (word_valid) begin
                  msg_state <= MSG_ACTIVE;
               end
            end
            MSG_ACTIVE: begin
               if (word_valid) begin
                  msg_state <= MSG_ACTIVE;
               end else if (idle_hit) begin
                  msg_state <= MSG_IDLE;
               end
            end
            default: begin
               msg_state <= MSG_IDLE;
            end
         endcase
         if (word_valid) begin
            code_byte <= pay;
         end
         new_message_flag <= word_valid
            || (new_message_flag && !rd_code);
         return_to_idle_flag <= (idle_hit && !word_valid
            && msg_state == MSG_ACTIVE)
            || (return_to_idle_flag && !rd_status);
      end
   end

   // Payload stack, oldest entry at index 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill      <= '0;
         last_code <= '0;
         from_idle <= 1'b1;
         for (int i = 0; i < DEPTH; i++) begin
            stack[i] <= '0;
         end
      end else if (clk_en) begin
         if (!channel_enable) begin
            fill      <= '0;
            from_idle <= 1'b1;
         end else begin
            if (idle_hit) begin
               from_idle <= 1'b1;
            end else if (push) begin
               from_idle <= 1'b0;
            end
            if (word_valid) begin
               last_code <= pay;
            end
            if (pop || (push && fill == DEPTH_C)) begin
               for (int i = 0; i < DEPTH - 1; i++) begin
                  stack[i] <= stack[i+1];
               end
            end
            if (push) begin
               if (pop) begin
                  stack[fill - ONE_C] <= pay;
               end else if (fill == DEPTH_C) begin
                  stack[DEPTH-1] <= pay;
               end else begin
                  stack[fill] <= pay;
                  fill <= fill + ONE_C;
               end
            end else if (pop) begin
               fill <= fill - ONE_C;
            end
         end
      end
   end

   // Configuration register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= farx_pkg::CONFIG_RESET;
      end else if (clk_en) begin
         if (acc && pwrite && paddr == farx_pkg::ADDR_CONFIG) begin
            cfg <= pwdata[3:0];
         end
      end
   end

   // APB answer: ready one cycle after a setup taken with clk_en high, so such an access has no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (clk_en) begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable) begin
            if (paddr == farx_pkg::ADDR_CONFIG) begin
               prdata[3:0] <= cfg;
            end else if (paddr == farx_pkg::ADDR_STATUS) begin
               prdata[farx_pkg::ST_NEW_MSG]   <= new_message_flag;
               prdata[farx_pkg::ST_TO_IDLE]   <= return_to_idle_flag;
               prdata[farx_pkg::ST_NOT_EMPTY] <= stack_not_empty;
               prdata[farx_pkg::ST_IN_MSG]    <= (msg_state == MSG_ACTIVE);
            end else if (paddr == farx_pkg::ADDR_CODE) begin
               prdata[PW:1] <= code_byte;
            end else if (paddr == farx_pkg::ADDR_STACK) begin
               if (stack_not_empty) begin
                  prdata[PW-1:0] <= stack[0];
                  prdata[farx_pkg::SK_VALID] <= 1'b1;
                  prdata[farx_pkg::SK_MORE]  <= (fill > ONE_C);
               end
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // Interrupt line, each source under its own mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= (new_message_flag && cfg.new_message_irq_enable)
            || (return_to_idle_flag && cfg.return_to_idle_irq_enable)
            || (stack_not_empty && cfg.stack_not_empty_irq_enable);
      end
   end

endmodule
`default_nettype wire

// [test/farx_line_model.sv]
// Remote line end: serialises code words onto the C13 overhead stream.
// Assumes pclk from the bench; every change lands just after a rise.
`default_nettype none
module farx_line_model (
   input  wire logic pclk,
   output var  logic c13_bit,
   output var  logic c13_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      c13_bit = 1'b0;
      c13_valid = 1'b0;
   end
   // First bit of w goes first; gaps toggle the level so a stale bit
   // never looks like a held one
   task automatic send(input logic [15:0] w, input int gap);
      for (int i = 0; i < 16; i++) begin
         @(posedge pclk);
         c13_bit <= w[i];
         c13_valid <= 1'b1;
         for (int g = 0; g < gap; g++) begin
            @(posedge pclk);
            c13_valid <= 1'b0;
            c13_bit <= (g % 2) ? w[i] : ~w[i];
         end
      end
      @(posedge pclk);
      c13_valid <= 1'b0;
      c13_bit <= ~c13_bit;
   endtask
endmodule
`default_nettype wire

// [test/farx_receiver_props.sv]
// Port-level checks for the far-end alarm code receiver.
// Assumes it is bound to the receiver and sees only its ports.
`default_nettype none
module farx_props (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                clk_en,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire farx_pkg::farx_fmt_t line_format,
   input wire logic                channel_enable,
   input wire logic                c13_bit,
   input wire logic                c13_valid,
   input wire logic                irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic       acc;
   logic [3:1] ie_q;
   assign acc = psel && penable && pready;
   // Mask shadow moves at the same edge as the register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_q <= 3'h0;
      end else if (acc && pwrite && paddr == farx_pkg::ADDR_CONFIG) begin
         ie_q <= pwdata[3:1];
      end
   end
   a_ready_next: assert property (psel && !penable && clk_en |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_unmapped: assert property (pready && paddr > 12'h00f |-> pslverr)
      else $error("unmapped access without error");
   a_err_mapped: assert property (pready && paddr inside
      {12'h000, 12'h004, 12'h008, 12'h00c} |-> !pslverr)
      else $error("mapped access with error");
   a_data_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_code_frame: assert property (acc && !pwrite && paddr == 12'h008
      |-> prdata[0] == 1'b0 && prdata[31:7] == 25'h0)
      else $error("code byte zero bits wrong");
   a_stack_more: assert property (acc && !pwrite && paddr == 12'h00c
      && !prdata[6] |-> !prdata[7])
      else $error("more bit set without valid");
   a_irq_masked: assert property ((ie_q == 3'h0) [*2] |-> !irq)
      else $error("interrupt while all masked");
   a_status_pad: assert property (acc && !pwrite && paddr == 12'h004
      |-> prdata[31:4] == 28'h0)
      else $error("status upper bits set");
endmodule
bind farx_receiver farx_props chk (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .line_format(line_format),
   .channel_enable(channel_enable), .c13_bit(c13_bit),
   .c13_valid(c13_valid), .irq(irq));
`default_nettype wire

// [test/farx_receiver_tb.sv]
// Self-checking bench for the far-end alarm code receiver.
// Assumes the line model feeds C13 bits and the bench is the APB host.
`default_nettype none
module farx_receiver_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        c13_bit;
   logic        c13_valid;
   logic        chan_en = 1'b1;
   logic        clk_en = 1'b1;
   logic        err;
   logic [31:0] r;
   logic [5:0]  m_code, last, tent, alt, a, e;
   logic [3:0]  cfg;
   logic [5:0]  q[$];
   farx_pkg::farx_fmt_t fmt = farx_pkg::FMT_DS3_CBIT;
   bit          m_new, m_idle, m_msg, idle_seen;
   int          st, cnt, bad_count, cmp_count;
   int          seed = 34;
   always #10 pclk = ~pclk;
   farx_receiver DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line_format(fmt), .channel_enable(chan_en),
      .c13_bit(c13_bit), .c13_valid(c13_valid), .irq(irq));
   farx_line_model lm (.pclk(pclk), .c13_bit(c13_bit),
      .c13_valid(c13_valid));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0);
      chk(r, exp);
   endtask
   task automatic setcfg(input logic [3:0] c);
      apb(1'b1, farx_pkg::ADDR_CONFIG, {28'h0, c});
      cfg = c;
      st = 0;
   endtask
   function automatic void declare(input logic [5:0] p);
      m_new = 1;
      m_msg = 1;
      m_code = p;
      if (q.size() == 0 || idle_seen || p != last) begin
         if (q.size() == 3) void'(q.pop_front());
         q.push_back(p);
         idle_seen = 0;
      end
      last = p;
   endfunction
   // Reference of the nine-repeat hunt, stepped once per pattern
   function automatic void model(input logic [5:0] p);
      if (cfg[0]) declare(p);
      else if (st == 0) begin
         tent = p;
         cnt = 1;
         st = 1;
      end else if (p == tent) begin
         cnt += (st == 2) ? 2 : 1;
         st = 1;
         if (cnt >= 9) begin
            declare(tent);
            st = 0;
         end
      end else if (st == 1) begin
         alt = p;
         st = 2;
      end else begin
         tent = alt;
         cnt = (p == alt) ? 2 : 1;
         st = (p == alt) ? 1 : 2;
         alt = p;
      end
   endfunction
   task automatic settle(input bit rdcode);
      repeat (3) @(posedge pclk);
      chk(irq, (m_new & cfg[1]) | (m_idle & cfg[2])
         | ((q.size() > 0) & cfg[3]));
      rdc(12'h004, {28'h0, m_msg, q.size() > 0, m_idle, m_new});
      m_idle = 0;
      if (rdcode && m_new) rdc(12'h008, {25'h0, m_code, 1'b0});
      if (rdcode) m_new = 0;
   endtask
   task automatic word(input logic [15:0] w, input bit act, input bit rc);
      lm.send(w, $random(seed) & 3);
      if (act) model(w[14:9]);
      settle(rc);
   endtask
   task automatic idle();
      lm.send(16'hffff, $random(seed) & 1);
      if (m_msg) m_idle = 1;
      m_msg = 0;
      idle_seen = 1;
      settle(1'b1);
   endtask
   task automatic drain();
      while (q.size() > 0) begin
         e = q.pop_front();
         rdc(12'h00c, {24'h0, q.size() > 0, 1'b1, e});
      end
      rdc(12'h00c, 32'h0);
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #1ms;
      bad_count++;
      results();
   end
   initial begin
      cfg = 4'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc(12'h000, 32'h0);
      rdc(12'h00c, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk(err, 1'b1);
      setcfg(4'hf);
      word({1'b0, 6'h2a, 1'b1, 8'hff}, 1'b0, 1'b1);
      idle();
      a = 6'($random(seed));
      for (int i = 0; i < 5; i++) word({1'b0, a + 6'(i / 2), 9'h0ff},
         1'b1, 1'b1);
      word({1'b0, ~a, 9'h0ff}, 1'b1, 1'b0);
      word({1'b0, a, 9'h0ff}, 1'b1, 1'b1);
      drain();
      idle();
      word({1'b0, a, 9'h0ff}, 1'b1, 1'b1);
      setcfg({3'($random(seed)), 1'b0});
      for (int i = 0; i < 70; i++) word({1'b0, ($random(seed) & 3) ? a :
         a ^ 6'h15, 9'h0ff}, 1'b1, 1'b1);
      drain();
      // Single mode, so a word taken while inactive would show at once
      setcfg(4'h1);
      for (int f = 0; f < 4; f++) begin
         fmt <= farx_pkg::farx_fmt_t'(f);
         if (f != 1) word({1'b0, ~a, 9'h0ff}, 1'b0, 1'b1);
      end
      fmt <= farx_pkg::FMT_DS3_CBIT;
      word({1'b0, ~a, 9'h0ff}, 1'b1, 1'b1);
      // A word sent while frozen must leave no trace
      clk_en <= 1'b0;
      lm.send({1'b0, a, 9'h0ff}, 0);
      clk_en <= 1'b1;
      settle(1'b1);
      chan_en <= 1'b0;
      repeat (4) @(posedge pclk);
      chan_en <= 1'b1;
      rdc(12'h00c, 32'h0);
      q.delete();
      idle_seen = 1;
      word({1'b0, ~a, 9'h0ff}, 1'b1, 1'b1);
      drain();
      results();
   end
endmodule
`default_nettype wire
